// >>> include/wdt_pkg.sv
// Package: register indices, keys, field positions and timing constants
package wdt_pkg;
  localparam logic [7:0] KEY_UNLOCK       = 8'h87;
  localparam logic [7:0] KEY_LOCK         = 8'haa;
  localparam logic [7:0] REG_FUNC_SEL     = 8'h07;
  localparam logic [7:0] REG_ACTIVATE     = 8'h30;
  localparam logic [7:0] REG_UNIT         = 8'hf5;
  localparam logic [7:0] REG_COUNT        = 8'hf6;
  localparam logic [7:0] REG_CTRL         = 8'hf7;
  localparam logic [7:0] FUNC_WATCHDOG    = 8'h08;
  localparam logic [7:0] ACTIVATE_ON      = 8'h01;
  localparam int         UNIT_MINUTE_BIT  = 3;
  localparam int         CTRL_MOUSE_BIT   = 7;
  localparam int         CTRL_KBD_BIT     = 6;
  localparam int         CTRL_FORCE_BIT   = 5;
  localparam int         CTRL_STATUS_BIT  = 4;
  localparam logic [7:0] COUNT_RESET      = 8'h00;
  localparam logic [7:0] UNIT_RESET       = 8'h00;
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam int         CLK_HZ           = 100_000_000;
  localparam int         SECOND_S         = 1;
  localparam int         SECOND_CYCLES    = CLK_HZ * SECOND_S;
  localparam int         MINUTE_SECONDS   = 60;
endpackage

// >>> include/tick_if.sv
// Interface: tick strobes from the prescaler to the watchdog core
interface tick_if;
  logic restart;
  logic minute_unit;
  logic tick;
  modport core (output restart, output minute_unit, input tick);
  modport presc (input restart, input minute_unit, output tick);
endinterface

// >>> design/wdt_prescaler.sv
// Prescaler: one tick strobe per second, or per minute when minute_unit is set, from the system clock
module wdt_prescaler #(
  parameter int SEC_CYCLES = wdt_pkg::SECOND_CYCLES,
  parameter int MIN_SECS   = wdt_pkg::MINUTE_SECONDS
) (
  input wire logic clk,
  input wire logic arst_n,
  tick_if.presc    tk
);
  // The seconds counter is eight bits wide, so a minute cannot exceed 256 seconds
  if (SEC_CYCLES < 2 || MIN_SECS < 1 || MIN_SECS > 256) begin
    $error("prescaler counts out of range");
  end
  typedef struct packed {
    logic [31:0] cyc;
    logic [7:0]  secs;
    logic        tick;
  } presc_state_type;
  presc_state_type s_q;
  presc_state_type s_d;
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (tk.restart) begin
      s_d.cyc = '0;
      s_d.secs = '0;
    end else if (s_q.cyc == 32'(SEC_CYCLES - 1)) begin
      s_d.cyc = '0;
      if (!tk.minute_unit) begin
        s_d.tick = 1'b1;
      end else if (s_q.secs == 8'(MIN_SECS - 1)) begin
        s_d.secs = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.secs = s_q.secs + 8'h01;
      end
    end else begin
      s_d.cyc = s_q.cyc + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tk.tick = s_q.tick;
endmodule

// >>> design/indexed_port_watchdog_timer.sv
// Watchdog timer behind an index/data port pair with key-guarded configuration
module indexed_port_watchdog_timer #(
  parameter logic [15:0] INDEX_ADDR = 16'h002e,
  parameter int          SEC_CYCLES = wdt_pkg::SECOND_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rvalid,
  input  wire logic        kbd_activity,
  input  wire logic        mouse_activity,
  input  wire logic        action_select_jumper,
  output logic             wdt_reset,
  output logic             wdt_irq11_n
);
  if (INDEX_ADDR[0] != 1'b0 || SEC_CYCLES < 2) begin
    $error("index port must be even and a second at least two cycles");
  end

  typedef enum logic [1:0] {
    LOCKED  = 2'b00,
    ONE_KEY = 2'b01,
    OPEN    = 2'b11
  } cfg_state_type;

  typedef struct packed {
    cfg_state_type cfg;
    logic [7:0]    index;
    logic [7:0]    func;
    logic          active;
    logic          minute;
    logic [7:0]    count_reg;
    logic [7:0]    remain;
    logic          kbd_en;
    logic          mouse_en;
    logic          expired;
    logic [7:0]    rdata;
    logic          rvalid;
    logic          rst_out;
    logic          irq_n;
  } wdt_state_type;

  wdt_state_type s_q;
  wdt_state_type s_d;
  tick_if tk ();

  wdt_prescaler #(
    .SEC_CYCLES (SEC_CYCLES),
    .MIN_SECS   (wdt_pkg::MINUTE_SECONDS)
  ) u_presc (
    .clk    (clk),
    .arst_n (arst_n),
    .tk     (tk)
  );

  function automatic logic wd_sel(input wdt_state_type s);
    return s.cfg == OPEN && s.func == wdt_pkg::FUNC_WATCHDOG;
  endfunction

  logic idx_hit;
  logic dat_hit;
  logic dat_wr;
  logic cnt_wr;
  logic reload;
  logic force_to;
  logic key_wr;
  assign idx_hit = io_addr == INDEX_ADDR;
  assign dat_hit = io_addr == INDEX_ADDR + 16'h0001;
  assign dat_wr  = io_wr && dat_hit && s_q.cfg == OPEN;
  assign cnt_wr  = dat_wr && wd_sel(s_q) && s_q.index == wdt_pkg::REG_COUNT;
  assign force_to = dat_wr && wd_sel(s_q) && s_q.index == wdt_pkg::REG_CTRL
                    && io_wdata[wdt_pkg::CTRL_FORCE_BIT];
  assign reload  = s_q.active && ((s_q.kbd_en && kbd_activity)
                    || (s_q.mouse_en && mouse_activity));
  assign tk.restart = cnt_wr || reload || !s_q.active;
  assign tk.minute_unit = s_q.minute;
  assign key_wr  = io_wr && idx_hit && io_wdata == wdt_pkg::KEY_UNLOCK;

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    if (io_wr && idx_hit) begin
      case (s_q.cfg)
        LOCKED:  s_d.cfg = io_wdata == wdt_pkg::KEY_UNLOCK ? ONE_KEY : LOCKED;
        ONE_KEY: s_d.cfg = io_wdata == wdt_pkg::KEY_UNLOCK ? OPEN : LOCKED;
        OPEN: begin
          if (io_wdata == wdt_pkg::KEY_LOCK) begin
            s_d.cfg = LOCKED;
          end else begin
            s_d.index = io_wdata;
          end
        end
        default: s_d.cfg = LOCKED;
      endcase
    end
    if (dat_wr) begin
      if (s_q.index == wdt_pkg::REG_FUNC_SEL) begin
        s_d.func = io_wdata;
      end else if (wd_sel(s_q)) begin
        case (s_q.index)
          wdt_pkg::REG_ACTIVATE: s_d.active = io_wdata == wdt_pkg::ACTIVATE_ON;
          wdt_pkg::REG_UNIT:     s_d.minute = io_wdata[wdt_pkg::UNIT_MINUTE_BIT];
          wdt_pkg::REG_COUNT: begin
            s_d.count_reg = io_wdata;
            s_d.remain    = io_wdata;
          end
          wdt_pkg::REG_CTRL: begin
            s_d.kbd_en   = io_wdata[wdt_pkg::CTRL_KBD_BIT];
            s_d.mouse_en = io_wdata[wdt_pkg::CTRL_MOUSE_BIT];
          end
          default: ;
        endcase
      end
    end
    // Reads always answer; locked reads return zero
    if (io_rd && dat_hit) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = 8'h00;
      if (s_q.cfg == OPEN) begin
        if (s_q.index == wdt_pkg::REG_FUNC_SEL) begin
          s_d.rdata = s_q.func;
        end else if (wd_sel(s_q)) begin
          case (s_q.index)
            wdt_pkg::REG_ACTIVATE: s_d.rdata = {7'h00, s_q.active};
            wdt_pkg::REG_UNIT:     s_d.rdata = {4'h0, s_q.minute, 3'h0};
            wdt_pkg::REG_COUNT:    s_d.rdata = s_q.count_reg;
            wdt_pkg::REG_CTRL:     s_d.rdata = {s_q.mouse_en, s_q.kbd_en, 1'b0,
                                                s_q.expired, 4'h0};
            default:               s_d.rdata = 8'h00;
          endcase
        end
      end
    end
    if (cnt_wr || reload) begin
      s_d.expired = 1'b0;
      if (reload && !cnt_wr) begin
        s_d.remain = s_q.count_reg;
      end
    end
    // Count zero halts; the prescaler is held while inactive
    if (s_q.active && s_q.remain != 8'h00 && tk.tick && !cnt_wr && !reload) begin
      s_d.remain = s_q.remain - 8'h01;
      if (s_q.remain == 8'h01) begin
        s_d.expired = 1'b1;
      end
    end
    if (force_to) begin
      s_d.expired = 1'b1;
    end
    if (!s_q.active) begin
      s_d.expired = 1'b0;
    end
    s_d.rst_out = s_d.expired && action_select_jumper;
    s_d.irq_n   = !(s_d.expired && !action_select_jumper);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q           <= '0;
      s_q.cfg       <= LOCKED;
      s_q.count_reg <= wdt_pkg::COUNT_RESET;
      s_q.irq_n     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign io_rdata    = s_q.rdata;
  assign io_rvalid   = s_q.rvalid;
  assign wdt_reset   = s_q.rst_out;
  assign wdt_irq11_n = s_q.irq_n;

  property p_locked_noop;
    @(posedge clk) disable iff (!arst_n)
      s_q.cfg != OPEN |=> $stable(s_q.count_reg) && $stable(s_q.active);
  endproperty
  a_locked_noop: assert property (p_locked_noop) else $error("locked write changed reg");

  // Keys may be spaced by idle cycles; only another index write cancels
  sequence s_first_key;
    s_q.cfg == LOCKED && key_wr ##1 s_q.cfg == ONE_KEY;
  endsequence
  sequence s_second_key;
    s_q.cfg == ONE_KEY && key_wr ##1 s_q.cfg == OPEN;
  endsequence
  property p_first_key;
    @(posedge clk) disable iff (!arst_n) s_q.cfg == LOCKED && key_wr |-> s_first_key;
  endproperty
  a_first_key: assert property (p_first_key) else $error("first key lost");

  property p_unlock;
    @(posedge clk) disable iff (!arst_n) s_q.cfg == ONE_KEY && key_wr |-> s_second_key;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock failed");

  property p_lock;
    @(posedge clk) disable iff (!arst_n)
      s_q.cfg == OPEN && io_wr && idx_hit && io_wdata == wdt_pkg::KEY_LOCK
      |=> s_q.cfg == LOCKED;
  endproperty
  a_lock: assert property (p_lock) else $error("lock failed");

  property p_count_write;
    @(posedge clk) disable iff (!arst_n)
      cnt_wr |=> s_q.remain == $past(io_wdata) && !s_q.expired;
  endproperty
  a_count_write: assert property (p_count_write) else $error("count not restarted");

  property p_zero_stops;
    @(posedge clk) disable iff (!arst_n)
      s_q.remain == 8'h00 && !cnt_wr && !reload |=> s_q.remain == 8'h00;
  endproperty
  a_zero_stops: assert property (p_zero_stops) else $error("zero count moved");

  sequence s_timeout_shown;
    s_q.expired && (wdt_reset || !wdt_irq11_n);
  endsequence

  property p_force;
    @(posedge clk) disable iff (!arst_n)
      force_to && s_q.active |=> s_timeout_shown;
  endproperty
  a_force: assert property (p_force) else $error("force timeout missed");

  property p_irq_hold;
    @(posedge clk) disable iff (!arst_n)
      !wdt_irq11_n && !cnt_wr && !reload && s_q.active && !io_wr
      |=> !wdt_irq11_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq released early");

  property p_jumper;
    @(posedge clk) disable iff (!arst_n)
      s_q.expired && $past(action_select_jumper) |-> wdt_reset && wdt_irq11_n;
  endproperty
  a_jumper: assert property (p_jumper) else $error("jumper select wrong");

  property p_reload;
    @(posedge clk) disable iff (!arst_n)
      reload && !cnt_wr && !force_to |=> s_q.remain == $past(s_q.count_reg) && !s_q.expired;
  endproperty
  a_reload: assert property (p_reload) else $error("reload failed");

  property p_decrement;
    @(posedge clk) disable iff (!arst_n)
      tk.tick && s_q.active && s_q.remain != 8'h00 && !cnt_wr && !reload
      |=> s_q.remain == $past(s_q.remain) - 8'h01;
  endproperty
  a_decrement: assert property (p_decrement) else $error("no decrement on tick");

  property p_cancel;
    @(posedge clk) disable iff (!arst_n)
      s_q.cfg == ONE_KEY && io_wr && idx_hit && !key_wr |=> s_q.cfg == LOCKED;
  endproperty
  a_cancel: assert property (p_cancel) else $error("partial unlock kept");

  property p_rd_answer;
    @(posedge clk) disable iff (!arst_n) io_rd && dat_hit |=> io_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

  property p_locked_read;
    @(posedge clk) disable iff (!arst_n)
      io_rd && dat_hit && s_q.cfg != OPEN |=> io_rvalid && io_rdata == 8'h00;
  endproperty
  a_locked_read: assert property (p_locked_read) else $error("locked read leaked");

  // Force bit is write-only, so status is the only live bit besides the enables
  property p_status_read;
    @(posedge clk) disable iff (!arst_n)
      io_rd && dat_hit && wd_sel(s_q) && s_q.index == wdt_pkg::REG_CTRL
      |=> io_rdata[wdt_pkg::CTRL_STATUS_BIT] == $past(s_q.expired)
          && !io_rdata[wdt_pkg::CTRL_FORCE_BIT];
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_func_route;
    @(posedge clk) disable iff (!arst_n)
      dat_wr && !wd_sel(s_q) && s_q.index != wdt_pkg::REG_FUNC_SEL
      |=> $stable(s_q.count_reg) && $stable(s_q.active) && $stable(s_q.minute);
  endproperty
  a_func_route: assert property (p_func_route) else $error("unrouted write landed");

  property p_activate;
    @(posedge clk) disable iff (!arst_n)
      dat_wr && wd_sel(s_q) && s_q.index == wdt_pkg::REG_ACTIVATE
      |=> s_q.active == ($past(io_wdata) == wdt_pkg::ACTIVATE_ON);
  endproperty
  a_activate: assert property (p_activate) else $error("activation wrong");

  property p_inactive;
    @(posedge clk) disable iff (!arst_n)
      !s_q.active |=> !s_q.expired && !wdt_reset && wdt_irq11_n;
  endproperty
  a_inactive: assert property (p_inactive) else $error("inactive timer expired");

  property p_unit_write;
    @(posedge clk) disable iff (!arst_n)
      dat_wr && wd_sel(s_q) && s_q.index == wdt_pkg::REG_UNIT
      |=> s_q.minute == $past(io_wdata[wdt_pkg::UNIT_MINUTE_BIT]);
  endproperty
  a_unit_write: assert property (p_unit_write) else $error("unit bit wrong");

  property p_ctrl_write;
    @(posedge clk) disable iff (!arst_n)
      dat_wr && wd_sel(s_q) && s_q.index == wdt_pkg::REG_CTRL
      |=> s_q.kbd_en == $past(io_wdata[wdt_pkg::CTRL_KBD_BIT])
          && s_q.mouse_en == $past(io_wdata[wdt_pkg::CTRL_MOUSE_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("enable bits wrong");

  property p_expire;
    @(posedge clk) disable iff (!arst_n)
      tk.tick && s_q.active && s_q.remain == 8'h01 && !cnt_wr && !reload
      |=> s_timeout_shown;
  endproperty
  a_expire: assert property (p_expire) else $error("expiry missed");

  property p_irq_select;
    @(posedge clk) disable iff (!arst_n)
      s_q.expired && !$past(action_select_jumper) |-> !wdt_irq11_n && !wdt_reset;
  endproperty
  a_irq_select: assert property (p_irq_select) else $error("irq select wrong");

  // A restart must keep the tick low for the two following cycles, never a stale tick
  property p_restart_presc;
    @(posedge clk) disable iff (!arst_n) cnt_wr || reload |=> !tk.tick [*2];
  endproperty
  a_restart_presc: assert property (p_restart_presc) else $error("stale tick");
endmodule

// >>> tb/host_port_model.sv
// Host model: drives index and data port cycles toward the watchdog
module host_port_model #(
  parameter logic [15:0] INDEX_ADDR = 16'h002e
) (
  input  wire logic        clk,
  output logic      [15:0] io_addr,
  output logic             io_wr,
  output logic             io_rd,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    io_addr  = 16'h0000;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end

  // Strobe rises just after one edge and falls just after the taking edge
  task automatic port_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr  = a;
    io_wdata = d;
    io_wr    = 1'b1;
    @(posedge clk);
    #1;
    io_wr    = 1'b0;
    io_wdata = ~d; // Released bus must not keep showing the old byte
  endtask

  // Read answer is registered, so it is seen just after the taking edge
  task automatic port_rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    #1;
    io_addr = a;
    io_rd   = 1'b1;
    @(posedge clk);
    #1;
    io_rd = 1'b0;
    v     = io_rvalid;
    d     = io_rdata;
  endtask

  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    port_wr(INDEX_ADDR, idx);
    port_wr(INDEX_ADDR + 16'h0001, d);
  endtask

  task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d, output logic v);
    port_wr(INDEX_ADDR, idx);
    port_rd(INDEX_ADDR + 16'h0001, d, v);
  endtask

  task automatic unlock();
    port_wr(INDEX_ADDR, wdt_pkg::KEY_UNLOCK);
    port_wr(INDEX_ADDR, wdt_pkg::KEY_UNLOCK);
  endtask

  task automatic lock();
    port_wr(INDEX_ADDR, wdt_pkg::KEY_LOCK);
  endtask
endmodule

// >>> tb/tb_top.sv
// Testbench: drives the watchdog through its port pair and checks outputs
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, arst_n, io_wr, io_rd, io_rvalid, rd_v;
  logic        kbd_activity, mouse_activity, action_select_jumper;
  logic        wdt_reset, wdt_irq11_n;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, rd_d;
  int          failures, check_count;

  // Short second keeps the minute case at 600 cycles
  indexed_port_watchdog_timer #(.INDEX_ADDR(16'h002e), .SEC_CYCLES(10)) i_dut (
    .clk(clk), .arst_n(arst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .kbd_activity(kbd_activity), .mouse_activity(mouse_activity),
    .action_select_jumper(action_select_jumper), .wdt_reset(wdt_reset),
    .wdt_irq11_n(wdt_irq11_n));

  host_port_model #(.INDEX_ADDR(16'h002e)) i_host (
    .clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_out(input logic use_rst, input logic lvl, input int n);
    int i;
    for (i = 0; i < n && ((use_rst ? wdt_reset : wdt_irq11_n) !== lvl); i++) cyc(1);
    if (i == n) begin
      failures++;
      $display("[ERR] timeout output exp %b got %b", lvl, use_rst ? wdt_reset : wdt_irq11_n);
      summarize();
    end
  endtask

  task automatic rd_chk(input string n, input logic [7:0] idx, input logic [7:0] e);
    i_host.reg_rd(idx, rd_d, rd_v);
    `CHK("rvalid", 1'b1, rd_v)
    `CHK(n, e, rd_d)
  endtask

  task automatic pulse(input logic kbd);
    kbd_activity   = kbd;
    mouse_activity = !kbd;
    cyc(1);
    kbd_activity   = 1'b0;
    mouse_activity = 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    arst_n = 1'b0;
    {kbd_activity, mouse_activity, action_select_jumper} = 3'b000;
    failures = 0;
    check_count = 0;
    cyc(16);
    arst_n = 1'b1;
    `CHK("irq_n", 1'b1, wdt_irq11_n)
    `CHK("reset", 1'b0, wdt_reset)
    rd_chk("locked", 8'hf6, 8'h00);
    i_host.unlock();
    i_host.reg_wr(8'h30, 8'h01);
    i_host.reg_wr(8'hf6, 8'h01);
    cyc(30);
    `CHK("no func", 1'b1, wdt_irq11_n)
    i_host.reg_wr(wdt_pkg::REG_FUNC_SEL, wdt_pkg::FUNC_WATCHDOG);
    rd_chk("func", 8'h07, 8'h08);
    rd_chk("ctrl rst", 8'hf7, 8'h00);
    i_host.reg_wr(8'h30, 8'h00);
    i_host.reg_wr(8'hf6, 8'h01);
    cyc(30);
    `CHK("inactive", 1'b1, wdt_irq11_n)
    i_host.reg_wr(8'h30, 8'h01);
    i_host.reg_wr(8'hf6, 8'h00);
    cyc(40);
    `CHK("stopped", 1'b1, wdt_irq11_n)
    i_host.reg_wr(8'hf6, 8'h03);
    cyc(20);
    i_host.reg_wr(8'hf6, 8'h03);
    cyc(25);
    `CHK("restart", 1'b1, wdt_irq11_n)
    wait_out(1'b0, 1'b0, 15);
    rd_chk("status", 8'hf7, 8'h10);
    cyc(50);
    `CHK("irq held", 1'b0, wdt_irq11_n)
    `CHK("no reset", 1'b0, wdt_reset)
    i_host.reg_wr(8'hf6, 8'h00);
    wait_out(1'b0, 1'b1, 4);
    rd_chk("cleared", 8'hf7, 8'h00);
    action_select_jumper = 1'b1;
    i_host.reg_wr(8'hf7, 8'h20);
    wait_out(1'b1, 1'b1, 4);
    `CHK("irq idle", 1'b1, wdt_irq11_n)
    rd_chk("force", 8'hf7, 8'h10);
    pulse(1'b1);
    cyc(3);
    `CHK("kbd off", 1'b1, wdt_reset)
    i_host.reg_wr(8'hf7, 8'h40);
    pulse(1'b1);
    wait_out(1'b1, 1'b0, 4);
    rd_chk("kbd en", 8'hf7, 8'h40);
    i_host.reg_wr(8'hf7, 8'ha0);
    wait_out(1'b1, 1'b1, 4);
    rd_chk("mouse en", 8'hf7, 8'h90);
    pulse(1'b0);
    wait_out(1'b1, 1'b0, 4);
    i_host.reg_wr(8'hf5, 8'h08);
    i_host.reg_wr(8'hf6, 8'h01);
    cyc(590);
    `CHK("minute", 1'b0, wdt_reset)
    wait_out(1'b1, 1'b1, 30);
    i_host.reg_wr(8'hf5, 8'h00);
    i_host.reg_wr(8'hf6, 8'h00);
    wait_out(1'b1, 1'b0, 4);
    i_host.lock();
    i_host.reg_wr(8'hf6, 8'h01);
    cyc(30);
    `CHK("locked wr", 1'b0, wdt_reset)
    i_host.port_wr(16'h002e, 8'h87);
    i_host.port_wr(16'h002e, 8'h07);
    i_host.port_wr(16'h002e, 8'h87);
    i_host.reg_wr(8'hf6, 8'h01);
    cyc(30);
    `CHK("partial", 1'b0, wdt_reset)
    // Mid-run reset must leave every watchdog register at its idle value
    arst_n = 1'b0;
    cyc(2);
    `CHK("rst irq", 1'b1, wdt_irq11_n)
    arst_n = 1'b1;
    i_host.unlock();
    rd_chk("func rst", 8'h07, 8'h00);
    i_host.reg_wr(8'h07, 8'h08);
    rd_chk("act rst", 8'h30, 8'h00);
    rd_chk("unit rst", 8'hf5, 8'h00);
    rd_chk("count rst", 8'hf6, 8'h00);
    rd_chk("ctrl rst2", 8'hf7, 8'h00);
    summarize();
  end
endmodule
